// >>> rtl/rsc_slave_regs.sv
/*
  SMBus slave and control registers of an eight-channel repeater:
  CRC value, slave register control, digital reset and control, and
  pin override control, plus the pin/register selection they steer.
  Assumes scl and the pins are asynchronous, the channel register
  file and CRC checker run on mclk_in, and SDA is open drain with an
  external pull-up resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none

module rsc_slave_regs (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // smbus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // device pins
  input wire logic signal_detect_threshold_pin_in,
  input wire logic signal_detect_in,
  input wire logic [1:0] receiver_presence_detect_pin_in,
  input wire logic mode_pin_in,
  // values from channel register file and crc checker
  input wire logic [7:0] expected_crc_in,
  input wire logic threshold_reg_in,
  input wire logic idle_reg_in,
  input wire logic [1:0] receiver_presence_detect_reg_in,
  input wire logic mode_reg_in,
  // steering outputs
  output logic channel_ctrl_enable_out,
  output logic threshold_sel_out,
  output logic idle_sel_out,
  output logic [1:0] receiver_presence_detect_sel_out,
  output logic mode_sel_out,
  // self-clearing reset pulses
  output logic regs_reset_out,
  output logic master_reset_out
);

  // ==========================================================
  // pin synchronisers
  logic [rsc_pkg::PIN_W-1:0] pins_s;
  logic scl_s;
  logic sda_s;

  rsc_pin_sync #(
    .W(rsc_pkg::PIN_W),
    .RST_VAL(rsc_pkg::PIN_IDLE)
  ) u_sync (
    .clk_in(mclk_in),
    .rst_in(sys_rst_in),
    .async_in({mode_pin_in, receiver_presence_detect_pin_in, signal_detect_in,
               signal_detect_threshold_pin_in, sda_in, scl_in}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];

  // ==========================================================
  // bus condition detection on the synchronised levels
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // remember last levels to find edges
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // start and stop are sda edges while scl stays high
  always_comb begin
    scl_rise = scl_s & ~scl_prev_q;
    scl_fall = ~scl_s & scl_prev_q;
    bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  end

  // ==========================================================
  // smbus slave state
  rsc_pkg::rsc_smb_state_e state_q, state_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] ptr_q, ptr_d;
  logic host_ack_q, host_ack_d;
  logic sda_oe_q, sda_oe_d;
  logic wr_en;
  logic [7:0] rd_data;

  // register contents
  logic [7:0] crc_value_q, crc_value_d;
  logic [7:0] slave_ctrl_q, slave_ctrl_d;
  logic [7:0] dig_reset_q, dig_reset_d;
  logic [7:0] pin_ovr_q, pin_ovr_d;

  // read mux; unmapped offsets read as zero
  always_comb begin
    unique case (ptr_q)
      rsc_pkg::CRC_VALUE_OFS: rd_data = crc_value_q;
      rsc_pkg::SLAVE_CTRL_OFS: rd_data = slave_ctrl_q;
      rsc_pkg::DIG_RESET_OFS: rd_data = dig_reset_q;
      rsc_pkg::PIN_OVR_OFS: rd_data = pin_ovr_q;
      default: rd_data = 8'h00;
    endcase
  end

  // slave next state; a byte is every 8 scl rises, acks driven after falls
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bit_cnt_d = bit_cnt_q;
    ptr_d = ptr_q;
    host_ack_d = host_ack_q;
    sda_oe_d = sda_oe_q;
    wr_en = 1'b0;
    if (bus_start) begin
      // repeated start is legal from any state
      state_d = rsc_pkg::ST_ADDR;
      bit_cnt_d = 4'h0;
      sda_oe_d = 1'b0;
    end else if (bus_stop) begin
      state_d = rsc_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      unique case (state_q)
        rsc_pkg::ST_IDLE: begin
          sda_oe_d = 1'b0;
        end
        // receive address, register and data bytes
        rsc_pkg::ST_ADDR, rsc_pkg::ST_REG, rsc_pkg::ST_WDAT: begin
          if (scl_rise && bit_cnt_q != rsc_pkg::BYTE_BITS) begin
            shift_d = {shift_q[6:0], sda_s};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == rsc_pkg::BYTE_BITS) begin
            bit_cnt_d = 4'h0;
            if (state_q == rsc_pkg::ST_ADDR) begin
              // foreign address: stay off the bus until next start
              if (shift_q[7:1] == rsc_pkg::SLAVE_ADDR) begin
                state_d = rsc_pkg::ST_ADDR_ACK;
                sda_oe_d = 1'b1;
              end else begin
                state_d = rsc_pkg::ST_IDLE;
              end
            end else if (state_q == rsc_pkg::ST_REG) begin
              ptr_d = shift_q;
              state_d = rsc_pkg::ST_REG_ACK;
              sda_oe_d = 1'b1;
            end else begin
              // data byte commits as its ack starts
              wr_en = 1'b1;
              state_d = rsc_pkg::ST_WDAT_ACK;
              sda_oe_d = 1'b1;
            end
          end
        end
        rsc_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (shift_q[0]) begin
              // read: first data bit goes out on this fall
              state_d = rsc_pkg::ST_RDAT;
              // pointer steps as each byte loads, so an acked byte reads the next offset
              ptr_d = ptr_q + 8'h01;
              shift_d = {rd_data[6:0], 1'b0};
              sda_oe_d = ~rd_data[7];
              bit_cnt_d = 4'h1;
            end else begin
              state_d = rsc_pkg::ST_REG;
              sda_oe_d = 1'b0;
            end
          end
        end
        rsc_pkg::ST_REG_ACK: begin
          if (scl_fall) begin
            state_d = rsc_pkg::ST_WDAT;
            sda_oe_d = 1'b0;
          end
        end
        rsc_pkg::ST_WDAT_ACK: begin
          if (scl_fall) begin
            // further bytes of the same write go to the next offset
            ptr_d = ptr_q + 8'h01;
            state_d = rsc_pkg::ST_WDAT;
            sda_oe_d = 1'b0;
          end
        end
        rsc_pkg::ST_RDAT: begin
          if (scl_fall) begin
            if (bit_cnt_q == rsc_pkg::BYTE_BITS) begin
              state_d = rsc_pkg::ST_RDAT_ACK;
              sda_oe_d = 1'b0;
            end else begin
              sda_oe_d = ~shift_q[7];
              shift_d = {shift_q[6:0], 1'b0};
              bit_cnt_d = bit_cnt_q + 4'h1;
            end
          end
        end
        rsc_pkg::ST_RDAT_ACK: begin
          if (scl_rise) begin
            host_ack_d = ~sda_s;
          end else if (scl_fall) begin
            if (host_ack_q) begin
              ptr_d = ptr_q + 8'h01;
              state_d = rsc_pkg::ST_RDAT;
              shift_d = {rd_data[6:0], 1'b0};
              sda_oe_d = ~rd_data[7];
              bit_cnt_d = 4'h1;
            end else begin
              // nack ends the read; wait for stop
              state_d = rsc_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_d = rsc_pkg::ST_IDLE;
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  // register slave state
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_q <= rsc_pkg::ST_IDLE;
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      ptr_q <= 8'h00;
      host_ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_d;
      ptr_q <= ptr_d;
      host_ack_q <= host_ack_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  // ==========================================================
  // control registers
  logic regs_reset_d;
  logic master_reset_d;

  // self-clearing bits act one cycle after the write, then drop
  always_comb begin
    crc_value_d = crc_value_q;
    slave_ctrl_d = slave_ctrl_q;
    dig_reset_d = dig_reset_q;
    pin_ovr_d = pin_ovr_q;
    regs_reset_d = 1'b0;
    master_reset_d = 1'b0;
    if (dig_reset_q[rsc_pkg::RESET_MASTER_BIT]) begin
      master_reset_d = 1'b1;
      dig_reset_d[rsc_pkg::RESET_MASTER_BIT] = 1'b0;
    end
    if (dig_reset_q[rsc_pkg::RESET_REGS_BIT]) begin
      regs_reset_d = 1'b1;
      crc_value_d = rsc_pkg::CRC_VALUE_RST;
      slave_ctrl_d = rsc_pkg::SLAVE_CTRL_RST;
      dig_reset_d = rsc_pkg::DIG_RESET_RST;
      pin_ovr_d = rsc_pkg::PIN_OVR_RST;
    end
    // a new write lands after the clear so it is never lost
    if (wr_en) begin
      unique case (ptr_q)
        rsc_pkg::CRC_VALUE_OFS: crc_value_d = shift_q;
        rsc_pkg::SLAVE_CTRL_OFS: slave_ctrl_d = shift_q;
        rsc_pkg::DIG_RESET_OFS: dig_reset_d = shift_q;
        rsc_pkg::PIN_OVR_OFS: pin_ovr_d = shift_q;
        // unmapped offset: acked on the bus, dropped here
        default: begin
        end
      endcase
    end
  end

  // register the control bank
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      crc_value_q <= rsc_pkg::CRC_VALUE_RST;
      slave_ctrl_q <= rsc_pkg::SLAVE_CTRL_RST;
      dig_reset_q <= rsc_pkg::DIG_RESET_RST;
      pin_ovr_q <= rsc_pkg::PIN_OVR_RST;
    end else begin
      crc_value_q <= crc_value_d;
      slave_ctrl_q <= slave_ctrl_d;
      dig_reset_q <= dig_reset_d;
      pin_ovr_q <= pin_ovr_d;
    end
  end

  // ==========================================================
  // steering outputs, all registered
  logic ch_en_q, ch_en_d;
  logic thr_q, thr_d;
  logic idle_q, idle_d;
  logic [1:0] rxd_q, rxd_d;
  logic mode_q, mode_d;
  logic regs_rst_q;
  logic master_rst_q;

  // channel enable from crc match or enable bit; pin or register selection per override bit
  always_comb begin
    ch_en_d = slave_ctrl_q[rsc_pkg::REG_ENABLE_BIT] | (crc_value_q == expected_crc_in);
    thr_d = pin_ovr_q[rsc_pkg::OVR_THRESHOLD_BIT] ? threshold_reg_in : pins_s[2];
    idle_d = pin_ovr_q[rsc_pkg::OVR_IDLE_BIT] ? idle_reg_in : ~pins_s[3];
    rxd_d = pin_ovr_q[rsc_pkg::OVR_RX_DETECT_BIT] ? receiver_presence_detect_reg_in : pins_s[5:4];
    mode_d = pin_ovr_q[rsc_pkg::OVR_MODE_BIT] ? mode_reg_in : pins_s[6];
  end

  // register steering and pulses
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ch_en_q <= 1'b0;
      thr_q <= 1'b0;
      idle_q <= 1'b0;
      rxd_q <= 2'h0;
      mode_q <= 1'b0;
      regs_rst_q <= 1'b0;
      master_rst_q <= 1'b0;
    end else begin
      ch_en_q <= ch_en_d;
      thr_q <= thr_d;
      idle_q <= idle_d;
      rxd_q <= rxd_d;
      mode_q <= mode_d;
      regs_rst_q <= regs_reset_d;
      master_rst_q <= master_reset_d;
    end
  end

  // open drain: data level fixed low, enable does the signalling
  always_ff @(posedge mclk_in) begin
    sda_out <= 1'b0;
  end

  assign sda_oe_out = sda_oe_q;
  assign channel_ctrl_enable_out = ch_en_q;
  assign threshold_sel_out = thr_q;
  assign idle_sel_out = idle_q;
  assign receiver_presence_detect_sel_out = rxd_q;
  assign mode_sel_out = mode_q;
  assign regs_reset_out = regs_rst_q;
  assign master_reset_out = master_rst_q;

endmodule : rsc_slave_regs

`default_nettype wire

// >>> rtl/rsc_pkg.sv
/*
  Constants shared by the repeater slave control register block:
  register offsets, field positions, reset values, the SMBus slave
  address and the slave state encoding.
  Assumes every file names these constants as rsc_pkg::name.
*/
package rsc_pkg;

  // ==========================================================
  // register offsets (byte addresses on the SMBus)
  localparam logic [7:0] CRC_VALUE_OFS = 8'h05;
  localparam logic [7:0] SLAVE_CTRL_OFS = 8'h06;
  localparam logic [7:0] DIG_RESET_OFS = 8'h07;
  localparam logic [7:0] PIN_OVR_OFS = 8'h08;

  // ==========================================================
  // reset values
  localparam logic [7:0] CRC_VALUE_RST = 8'h00;
  localparam logic [7:0] SLAVE_CTRL_RST = 8'h10;
  localparam logic [7:0] DIG_RESET_RST = 8'h01;
  localparam logic [7:0] PIN_OVR_RST = 8'h00;

  // ==========================================================
  // field positions
  localparam int REG_ENABLE_BIT = 3;
  localparam int RESET_REGS_BIT = 6;
  localparam int RESET_MASTER_BIT = 5;
  localparam int OVR_THRESHOLD_BIT = 6;
  localparam int OVR_IDLE_BIT = 4;
  localparam int OVR_RX_DETECT_BIT = 3;
  localparam int OVR_MODE_BIT = 2;

  // ==========================================================
  // smbus slave address, 7 bits, value arbitrary
  localparam logic [6:0] SLAVE_ADDR = 7'h58;
  // bits in one smbus byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // width of the synchronised pin vector
  localparam int PIN_W = 7;
  // idle level of synchronised pins: scl and sda high
  localparam logic [6:0] PIN_IDLE = 7'h03;

  // ==========================================================
  // smbus slave states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_REG,
    ST_REG_ACK,
    ST_WDAT,
    ST_WDAT_ACK,
    ST_RDAT,
    ST_RDAT_ACK
  } rsc_smb_state_e;

endpackage : rsc_pkg

// >>> rtl/rsc_pin_sync.sv
/*
  Two-flop synchroniser for a vector of pin inputs.
  Assumes a single clock and a synchronous active-high reset; the
  reset value per bit is given by a parameter.
*/
`timescale 1ns/1ps
`default_nettype none

module rsc_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pins in, synchronised out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ==========================================================
  // per-bit two-stage chain; stage one feeds stage two only
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic stab_q;
      logic stab_d;
      // next values of the chain
      always_comb begin
        meta_d = async_in[i];
        stab_d = meta_q;
      end
      // register the chain
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          meta_q <= RST_VAL[i];
          stab_q <= RST_VAL[i];
        end else begin
          meta_q <= meta_d;
          stab_q <= stab_d;
        end
      end
      assign sync_out[i] = stab_q;
    end
  endgenerate

endmodule : rsc_pin_sync

`default_nettype wire

// >>> bench/rsc_slave_regs_props.sv
/*
  Checker for the repeater slave control block.
  Assumes it is bound to rsc_slave_regs and that pins stay steady around a register reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rsc_slave_regs_props (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // watched inputs
  input wire logic scl_in,
  input wire logic signal_detect_threshold_pin_in,
  input wire logic signal_detect_in,
  input wire logic mode_pin_in,
  input wire logic [7:0] expected_crc_in,
  // watched outputs
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic channel_ctrl_enable_out,
  input wire logic threshold_sel_out,
  input wire logic idle_sel_out,
  input wire logic mode_sel_out,
  input wire logic regs_reset_out,
  input wire logic master_reset_out
);
  // ==========================================
  // one clock domain, one reset
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  property p_sda_low; sda_out == 1'b0; endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda_out driven high");
  // ack moves only in scl low
  property p_oe_scl; $changed(sda_oe_out) |-> !$past(scl_in, 2); endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("sda_oe_out moved with scl high");
  property p_rr_one; regs_reset_out |=> !regs_reset_out; endproperty
  a_rr_one: assert property (p_rr_one) else $error("register reset pulse too long");
  property p_mr_one; master_reset_out |=> !master_reset_out; endproperty
  a_mr_one: assert property (p_mr_one) else $error("master reset pulse too long");
  property p_ce_dflt; regs_reset_out |=> channel_ctrl_enable_out == (expected_crc_in == 8'h00); endproperty
  a_ce_dflt: assert property (p_ce_dflt) else $error("channel enable wrong after reset");
  property p_thr_dflt; regs_reset_out |=> threshold_sel_out == signal_detect_threshold_pin_in; endproperty
  a_thr_dflt: assert property (p_thr_dflt) else $error("threshold not on pin");
  property p_idle_dflt; regs_reset_out |=> idle_sel_out == !signal_detect_in; endproperty
  a_idle_dflt: assert property (p_idle_dflt) else $error("idle not on detector");
  property p_mode_dflt; regs_reset_out |=> mode_sel_out == mode_pin_in; endproperty
  a_mode_dflt: assert property (p_mode_dflt) else $error("mode not on pin");
  // main scenarios seen
  c_rr: cover property (regs_reset_out);
  c_mr: cover property (master_reset_out);
  c_ack: cover property ($rose(sda_oe_out));
endmodule : rsc_slave_regs_props
`default_nettype wire

// >>> bench/rsc_smb_host.sv
/*
  SMBus host model: start, stop, byte transfers, register write and read.
  Assumes sda_in is the resolved wire with pull-up; scl stands high between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module rsc_smb_host (
  // clock
  input wire logic clk_in,
  // bus
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // idle bus: both released
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick
  // phases of 8 cycles keep well above the 6 cycle minimum
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = ~b;
    tick(8);
    scl_out = 1'b1;
    tick(4);
    r = sda_in;
    tick(4);
    scl_out = 1'b0;
    tick(1);
  endtask : bit_io
  task automatic start();
    sda_low_out = 1'b0;
    tick(4);
    scl_out = 1'b1;
    tick(8);
    sda_low_out = 1'b1;
    tick(8);
    scl_out = 1'b0;
    tick(1);
  endtask : start
  task automatic stop();
    sda_low_out = 1'b1;
    tick(8);
    scl_out = 1'b1;
    tick(8);
    sda_low_out = 1'b0;
    tick(8);
  endtask : stop
  // msb first, ninth bit released: ack from device or nack from us
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(1'b1, a);
    ack = ~a;
  endtask : xfer
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2;
    start();
    xfer({rsc_pkg::SLAVE_ADDR, 1'b0}, r, k0);
    xfer(a, r, k1);
    xfer(d, r, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, n;
    start();
    xfer({rsc_pkg::SLAVE_ADDR, 1'b0}, r, k0);
    xfer(a, r, k1);
    start();
    xfer({rsc_pkg::SLAVE_ADDR, 1'b1}, r, k2);
    xfer(8'hFF, d, n);
    stop();
    ok = k0 & k1 & k2;
  endtask : rd_reg
endmodule : rsc_smb_host
`default_nettype wire

// >>> bench/rsc_slave_regs_tb.sv
/*
  Testbench for the repeater slave control registers.
  Assumes the host model drives the bus and the checker is bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module rsc_slave_regs_tb;
  logic mclk = 1'b0, rst = 1'b1, scl, host_low, sda_w, dut_sda, dut_oe;
  logic thr = 1'b1, sd = 1'b1, mode = 1'b1, thr_r = 1'b0, idle_r = 1'b1, mode_r = 1'b0;
  logic [1:0] rpd = 2'b10, rpd_r = 2'b01, rpd_sel;
  logic [7:0] crc = 8'h5A, n_rr = 8'h00, n_mr = 8'h00, r;
  logic ce, thr_sel, idle_sel, mode_sel, rr, mr, ok, k;
  int mismatches = 0, tests_run = 0, cyc = 0;
  always #4 mclk = ~mclk;
  // open drain wire with pull-up
  assign sda_w = !(host_low || (dut_oe && !dut_sda));
  rsc_smb_host i_rsc_smb_host (.clk_in(mclk), .sda_in(sda_w), .scl_out(scl), .sda_low_out(host_low));
  rsc_slave_regs i_rsc_slave_regs (.mclk_in(mclk), .sys_rst_in(rst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(dut_sda), .sda_oe_out(dut_oe), .signal_detect_threshold_pin_in(thr), .signal_detect_in(sd),
    .receiver_presence_detect_pin_in(rpd), .mode_pin_in(mode), .expected_crc_in(crc), .threshold_reg_in(thr_r),
    .idle_reg_in(idle_r), .receiver_presence_detect_reg_in(rpd_r), .mode_reg_in(mode_r),
    .channel_ctrl_enable_out(ce), .threshold_sel_out(thr_sel), .idle_sel_out(idle_sel),
    .receiver_presence_detect_sel_out(rpd_sel), .mode_sel_out(mode_sel), .regs_reset_out(rr),
    .master_reset_out(mr));
  // pulse counters and hang guard
  always @(posedge mclk) begin
    n_rr <= n_rr + {7'h00, rr === 1'b1};
    n_mr <= n_mr + {7'h00, mr === 1'b1};
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_rsc_smb_host.wr_reg(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    i_rsc_smb_host.tick(4);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_rsc_smb_host.rd_reg(a, r, ok);
    chk({7'h00, ok}, 8'h01);
    chk(r, e);
  endtask : rd
  // ==========================================
  // reset values, unmapped read, foreign address
  task automatic t_reset_vals();
    rd(rsc_pkg::CRC_VALUE_OFS, rsc_pkg::CRC_VALUE_RST);
    rd(rsc_pkg::SLAVE_CTRL_OFS, rsc_pkg::SLAVE_CTRL_RST);
    rd(rsc_pkg::DIG_RESET_OFS, rsc_pkg::DIG_RESET_RST);
    rd(rsc_pkg::PIN_OVR_OFS, rsc_pkg::PIN_OVR_RST);
    rd(8'h0A, 8'h00);
    i_rsc_smb_host.start();
    i_rsc_smb_host.xfer({rsc_pkg::SLAVE_ADDR ^ 7'h01, 1'b0}, r, k);
    i_rsc_smb_host.stop();
    chk({7'h00, k}, 8'h00);
  endtask : t_reset_vals
  // crc gate versus register enable
  task automatic t_crc();
    wr(rsc_pkg::SLAVE_CTRL_OFS, 8'h10);
    chk({7'h00, ce}, 8'h00);
    wr(rsc_pkg::CRC_VALUE_OFS, 8'h5A);
    chk({7'h00, ce}, 8'h01);
    wr(rsc_pkg::CRC_VALUE_OFS, 8'hA5);
    chk({7'h00, ce}, 8'h00);
    wr(rsc_pkg::SLAVE_CTRL_OFS, 8'h18);
    chk({7'h00, ce}, 8'h01);
    rd(rsc_pkg::SLAVE_CTRL_OFS, 8'h18);
  endtask : t_crc
  // each override bit alone, then none, then all
  task automatic t_override();
    logic [7:0] v[6] = '{8'h40, 8'h10, 8'h08, 8'h04, 8'h00, 8'h5C};
    for (int i = 0; i < 12; i++) begin
      logic [7:0] o;
      o = v[i % 6];
      // second pass with pins and register values inverted, so a stuck select shows
      if (i == 6) begin
        {thr, sd, rpd, mode, thr_r, idle_r, rpd_r, mode_r} = ~{thr, sd, rpd, mode, thr_r, idle_r, rpd_r, mode_r};
      end
      wr(rsc_pkg::PIN_OVR_OFS, o);
      chk({3'h0, thr_sel, idle_sel, rpd_sel, mode_sel}, {3'h0, o[6] ? thr_r : thr,
        o[4] ? idle_r : !sd, o[3] ? rpd_r : rpd, o[2] ? mode_r : mode});
    end
    rd(rsc_pkg::PIN_OVR_OFS, 8'h5C);
  endtask : t_override
  // self clearing resets
  task automatic t_self_clear();
    wr(rsc_pkg::CRC_VALUE_OFS, 8'h33);
    wr(rsc_pkg::DIG_RESET_OFS, 8'h41);
    chk(n_rr, 8'h01);
    chk({7'h00, ce}, 8'h00);
    rd(rsc_pkg::CRC_VALUE_OFS, 8'h00);
    rd(rsc_pkg::SLAVE_CTRL_OFS, 8'h10);
    rd(rsc_pkg::PIN_OVR_OFS, 8'h00);
    rd(rsc_pkg::DIG_RESET_OFS, 8'h01);
    chk({6'h00, rpd_sel}, {6'h00, rpd});
    wr(rsc_pkg::CRC_VALUE_OFS, 8'h33);
    wr(rsc_pkg::DIG_RESET_OFS, 8'h21);
    chk(n_mr, 8'h01);
    chk(n_rr, 8'h01);
    rd(rsc_pkg::DIG_RESET_OFS, 8'h01);
    rd(rsc_pkg::CRC_VALUE_OFS, 8'h33);
  endtask : t_self_clear
  initial begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    t_reset_vals();
    t_crc();
    t_override();
    t_self_clear();
    test_done();
  end
endmodule : rsc_slave_regs_tb
bind rsc_slave_regs rsc_slave_regs_props i_rsc_slave_regs_props (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .scl_in(scl_in), .signal_detect_threshold_pin_in(signal_detect_threshold_pin_in),
  .signal_detect_in(signal_detect_in), .mode_pin_in(mode_pin_in), .expected_crc_in(expected_crc_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .channel_ctrl_enable_out(channel_ctrl_enable_out),
  .threshold_sel_out(threshold_sel_out), .idle_sel_out(idle_sel_out), .mode_sel_out(mode_sel_out),
  .regs_reset_out(regs_reset_out), .master_reset_out(master_reset_out));
`default_nettype wire
